// [src/wdt_pkg.sv]
package wdt_pkg;
  // ----------------------------------------
  // register map (word byte addresses)
  // ----------------------------------------
  localparam logic [3:0] WDT_CSR_ADDR = 4'h0;
  localparam logic [3:0] WDT_CNT_ADDR = 4'h4;
  localparam logic [3:0] WDT_DIV_ADDR = 4'h8;
  localparam logic [3:0] WDT_IST_ADDR = 4'hC;
  localparam logic [1:0] WDT_IMSK_IDX = 2'h0;
  // ----------------------------------------
  // control/status field positions
  // ----------------------------------------
  localparam int WDT_OVF_BIT = 7;
  localparam int WDT_MWI_BIT = 6;
  localparam int WDT_MODE_BIT = 5;
  localparam int WDT_IWI_BIT = 4;
  localparam int WDT_IEN_BIT = 3;
  localparam logic [7:0] WDT_CSR_FIXED = 8'h57;
  localparam logic [7:0] WDT_CNT_MAX = 8'hFF;
  localparam logic [7:0] WDT_CNT_RST = 8'h00;
  localparam logic [15:0] WDT_DIV_RST = 16'h0000;
  // status bits: 0 overflow, 1 internal reset, 2 interval interrupt
  localparam int WDT_EV_OVF = 0;
  localparam int WDT_EV_RST = 1;
  localparam int WDT_EV_ITV = 2;
  localparam int WDT_NEV = 3;
  typedef struct packed {
    logic ovf;
    logic mode;
    logic ien;
  } wdt_ctl_s;
  typedef enum logic [2:0] {
    WDT_IDLE = 3'b001,
    WDT_RESP = 3'b010,
    WDT_WAIT = 3'b100
  } wdt_bus_e;
endpackage

// [src/wdt_tick.sv]
`timescale 1ns/100ps
`default_nettype none
// prescaler: one-cycle tick every (div+1) clocks
module wdt_tick
  import wdt_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [DW-1:0] div_in,
  output logic tick_out
);
  logic [DW-1:0] cnt;
  // counter reloads on reaching the divide value
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else if (cnt >= div_in) begin
      cnt <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [src/wdt_top.sv]
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
#(
  parameter int CW = 8,
  parameter int DW = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic int_reset_out,
  output logic itv_irq_out,
  output logic irq_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  wdt_ctl_s ctl;
  logic [CW-1:0] watchdog_counter;
  logic [DW-1:0] div;
  logic [WDT_NEV-1:0] ist;
  logic [WDT_NEV-1:0] imsk;
  logic ovf_seen;
  logic ovf_prev;
  logic tick;
  wdt_bus_e bst;
  logic ovf_ev;
  logic [WDT_NEV-1:0] ev;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wb;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  wdt_tick #(.DW(DW)) u_tick (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .div_in(div),
    .tick_out(tick)
  );

  // ----------------------------------------
  // bus slave: one wait cycle, answer in the next
  // ----------------------------------------
  // take the request in IDLE, acknowledge in RESP, drop in WAIT so a held
  // request is not taken twice
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bst <= WDT_IDLE;
    end else begin
      case (bst)
        WDT_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bst <= WDT_RESP;
          end
        end
        WDT_RESP: bst <= WDT_WAIT;
        WDT_WAIT: bst <= WDT_IDLE;
        default: bst <= WDT_IDLE;
      endcase
    end
  end

  // waitrequest is registered: low for the one cycle after a taken request,
  // never in the cycle that takes it
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(bst == WDT_IDLE && (avs_read_in || avs_write_in));
    end
  end

  // the access completes at the edge where waitrequest is low
  assign wr_acc = avs_write_in && !avs_waitrequest_out;
  assign rd_acc = avs_read_in && !avs_waitrequest_out;
  assign wb = avs_writedata_in[7:0];

  // ----------------------------------------
  // counter and overflow
  // ----------------------------------------
  assign ovf_ev = tick && (watchdog_counter == CW'(WDT_CNT_MAX));

  // up-count on tick, wrap to zero; software may preload
  // a preload wins over a step in the same cycle; the overflow of that step still fires
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_counter <= CW'(WDT_CNT_RST);
    end else if (wr_acc && hit(avs_address_in, WDT_CNT_ADDR) && avs_byteenable_in[0]) begin
      watchdog_counter <= wb[CW-1:0];
    end else if (tick) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // ----------------------------------------
  // control/status register
  // ----------------------------------------
  // the arm for clearing the flag is a read that saw it set
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_seen <= 1'b0;
    end else if (rd_acc && hit(avs_address_in, WDT_CSR_ADDR) && ctl.ovf) begin
      ovf_seen <= 1'b1;
    end else if (!ctl.ovf) begin
      ovf_seen <= 1'b0;
    end
  end

  // set beats clear; the auto-clear comes from the internal reset pulse
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl.ovf <= 1'b0;
    end else if (ovf_ev) begin
      ctl.ovf <= 1'b1;
    end else if (int_reset_out) begin
      ctl.ovf <= 1'b0;
    end else if (wr_acc && hit(avs_address_in, WDT_CSR_ADDR) && avs_byteenable_in[0]
                 && ovf_seen && !wb[WDT_OVF_BIT]) begin
      ctl.ovf <= 1'b0;
    end
  end

  // each field is guarded by the inhibit bit written alongside it;
  // writes need only byte enable 0 set; the other byte enables are ignored
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl.mode <= 1'b0;
      ctl.ien <= 1'b0;
    end else if (wr_acc && hit(avs_address_in, WDT_CSR_ADDR) && avs_byteenable_in[0]) begin
      if (!wb[WDT_MWI_BIT]) begin
        ctl.mode <= wb[WDT_MODE_BIT];
      end
      if (!wb[WDT_IWI_BIT]) begin
        ctl.ien <= wb[WDT_IEN_BIT];
      end
    end
  end

  // ----------------------------------------
  // overflow consequences
  // ----------------------------------------
  // reset pulse issued one cycle, then it clears the flag next edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      int_reset_out <= 1'b0;
      itv_irq_out <= 1'b0;
    end else begin
      int_reset_out <= ovf_ev && !ctl.mode;
      itv_irq_out <= ovf_ev && ctl.mode && ctl.ien;
    end
  end

  // ----------------------------------------
  // prescaler divide, interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= DW'(WDT_DIV_RST);
    end else if (wr_acc && hit(avs_address_in, WDT_DIV_ADDR)) begin
      div <= avs_writedata_in[DW-1:0];
    end
  end

  // flag value one cycle back; resets low like the flag, so no false rise
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_prev <= 1'b0;
    end else begin
      ovf_prev <= ctl.ovf;
    end
  end

  assign ev = {itv_irq_out, int_reset_out, ctl.ovf && !ovf_prev};

  // write one to clear, a new event wins over the clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ist <= '0;
      imsk <= '0;
    end else begin
      if (wr_acc && hit(avs_address_in, WDT_IST_ADDR) && avs_byteenable_in[1]) begin
        imsk <= avs_writedata_in[8 +: WDT_NEV];
      end
      if (wr_acc && hit(avs_address_in, WDT_IST_ADDR) && avs_byteenable_in[0]) begin
        ist <= (ist & ~avs_writedata_in[WDT_NEV-1:0]) | ev;
      end else begin
        ist <= ist | ev;
      end
    end
  end

  // level interrupt, one edge behind the status it follows
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ist & imsk);
    end
  end

  // ----------------------------------------
  // read data, registered with the acknowledge
  // ----------------------------------------
  // captured when the request is taken, so they stand through the answer cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= '0;
    end else if (bst == WDT_IDLE && avs_read_in) begin
      case (avs_address_in)
        WDT_CSR_ADDR: avs_readdata_out <= {24'h0, ctl.ovf, 1'b1, ctl.mode, 1'b1,
                                            ctl.ien, 3'h7};
        WDT_CNT_ADDR: avs_readdata_out <= 32'(watchdog_counter);
        WDT_DIV_ADDR: avs_readdata_out <= 32'(div);
        WDT_IST_ADDR: avs_readdata_out <= {16'h0, 5'h0, imsk, 5'h0, ist};
        default: avs_readdata_out <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence ovf_s;
    ovf_ev;
  endsequence

  ovf_sets_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovf_s |=> ctl.ovf) else $error("overflow flag not set");
  wd_reset_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovf_s and !ctl.mode |=> int_reset_out) else $error("no internal reset");
  auto_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    int_reset_out && !ovf_ev |=> !ctl.ovf) else $error("flag not auto cleared");
  itv_irq_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovf_s and ctl.mode and ctl.ien |=> itv_irq_out && ctl.ovf) else $error("no interval irq");
  irq_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    itv_irq_out |-> $past(ctl.ien) && $past(ctl.mode)) else $error("irq not gated");
  no_wd_irq_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    int_reset_out |-> !itv_irq_out) else $error("irq in watchdog mode");
  clr_arm_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(ctl.ovf) && !$past(int_reset_out) |-> $past(ovf_seen)) else $error("bad clear");
  mode_lock_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(ctl.mode) |-> $past(wr_acc) && !$past(wb[WDT_MWI_BIT]))
    else $error("mode changed while inhibited");
  ien_lock_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(ctl.ien) |-> $past(wr_acc) && !$past(wb[WDT_IWI_BIT]))
    else $error("enable changed while inhibited");
  cnt_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    tick && !wr_acc |=> watchdog_counter == $past(watchdog_counter) + 1'b1)
    else $error("counter did not step");

  // ----------------------------------------
  // checks: multi-step and negative cases
  // ----------------------------------------
  // watchdog overflow: reset pulse and flag stand together for one cycle
  sequence wd_ovf_s;
    ovf_ev && !ctl.mode;
  endsequence
  sequence wd_pulse_s;
    int_reset_out && ctl.ovf && !ovf_ev;
  endsequence

  // flag gone the edge after the pulse
  wd_flag_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    wd_ovf_s ##1 wd_pulse_s |=> !ctl.ovf) else $error("watchdog flag not one cycle");
  // the flag has no other source than the wrap
  ovf_only_wrap_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ctl.ovf) |-> $past(ovf_ev)) else $error("flag set without overflow");
  // without the arm only the internal reset may clear the flag
  flag_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ctl.ovf && !ovf_seen && !int_reset_out |=> ctl.ovf) else $error("flag cleared unarmed");
  // the arm comes only from a read that saw the flag set
  arm_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ovf_seen) |-> $past(rd_acc) && $past(ctl.ovf)) else $error("arm without read");
  // a stale arm must not survive a cleared flag
  arm_drop_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !ctl.ovf |=> !ovf_seen) else $error("arm kept after flag cleared");
  // interval overflow with the enable low stays quiet
  ien_block_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovf_s and ctl.mode and !ctl.ien |=> !itv_irq_out) else $error("masked irq raised");
  // the reset pulse only follows a watchdog-mode wrap
  rst_cause_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    int_reset_out |-> ctl.ovf && $past(ovf_ev) && !$past(ctl.mode))
    else $error("reset without watchdog overflow");
  // the interval interrupt comes with the flag setting
  itv_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    itv_irq_out |-> ctl.ovf && $past(ovf_ev)) else $error("irq apart from flag set");
  // no tick and no preload leaves the count alone
  cnt_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !tick && !wr_acc |=> $stable(watchdog_counter)) else $error("counter moved without tick");
endmodule
`default_nettype wire

// [testbench/wdt_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// one compare: counts it, reports a mismatch at once
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module wdt_top_bench;
  import wdt_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, rst_pulse, itv_pulse, irq;
  logic [31:0] got;
  int n;
  int failures = 0;
  int compares = 0;
  // ----------------------------------------
  // clock, reset and design
  // ----------------------------------------
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  wdt_top i_wdt_top (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .int_reset_out(rst_pulse), .itv_irq_out(itv_pulse), .irq_out(irq));
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // request held until the rising edge that samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    adr <= a;
    wdat <= d;
    rd_en <= ~w;
    wr_en <= w;
    do begin
      @(posedge mclk_in);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) `CHK("waitrequest", 1'b0, wreq)
    got = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  // cycles until a pulse output is seen high, bounded
  task automatic wait_hi(input int which, input int lim);
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while ((which ? itv_pulse : rst_pulse) !== 1'b1 && n < lim);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_inhibit();
    bus(1'b1, WDT_CSR_ADDR, 32'h78); // inhibits set, mode/ien must hold
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("csr inhibited", 8'h57, got[7:0] & 8'h7F)
    bus(1'b1, WDT_CSR_ADDR, 32'h38);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("csr mode only", 8'h77, got[7:0] & 8'h7F)
    bus(1'b1, WDT_CSR_ADDR, 32'h68);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("csr ien only", 8'h7F, got[7:0] & 8'h7F)
    $display("test inhibit done");
  endtask
  task automatic t_interval();
    bus(1'b1, WDT_DIV_ADDR, 32'h1);
    bus(1'b1, WDT_IST_ADDR, 32'h407);
    wait_hi(1, 1100);
    `CHK("first itv pulse", 1'b1, itv_pulse)
    `CHK("no reset in interval", 1'b0, rst_pulse)
    wait_hi(1, 1100);
    `CHK("itv period", 512, n)
    @(negedge mclk_in);
    `CHK("irq level", 1'b1, irq)
    // a clearing write before any read must leave the flag
    bus(1'b1, WDT_CSR_ADDR, 32'h50);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("flag kept", 8'hFF, got[7:0])
    bus(1'b1, WDT_CSR_ADDR, 32'hD0);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("flag write one", 8'hFF, got[7:0])
    bus(1'b1, WDT_CSR_ADDR, 32'h50);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("flag cleared", 8'h7F, got[7:0])
    bus(1'b1, WDT_IST_ADDR, 32'h407);
    repeat (2) @(negedge mclk_in); // status clears at the edge, the level one edge later
    `CHK("irq cleared", 1'b0, irq)
    $display("test interval done");
  endtask
  task automatic t_masked();
    bus(1'b1, WDT_CSR_ADDR, 32'h20);
    wait_hi(1, 1100);
    `CHK("itv blocked", 1'b0, itv_pulse)
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("flag without irq", 8'hF7, got[7:0])
    $display("test masked done");
  endtask
  task automatic t_watchdog();
    bus(1'b1, WDT_CSR_ADDR, 32'h00);
    wait_hi(0, 1100);
    `CHK("reset pulse", 1'b1, rst_pulse)
    `CHK("no itv in watchdog", 1'b0, itv_pulse)
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("flag auto cleared", 8'h57, got[7:0])
    bus(1'b0, WDT_IST_ADDR, 32'h0);
    `CHK("reset status", 1'b1, got[WDT_EV_RST])
    $display("test watchdog done");
  endtask
  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // runs take under 3000 cycles; 20000 leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    bus(1'b0, WDT_CNT_ADDR, 32'h0);
    bus(1'b0, WDT_CSR_ADDR, 32'h0);
    `CHK("csr reset", 8'h57, got[7:0] & 8'h7F)
    t_inhibit();
    t_interval();
    t_masked();
    t_watchdog();
    give_verdict();
  end
endmodule
`default_nettype wire
